/* verilog/uhs_neg_pkg.sv */
// Constants shared by the card-side signalling negotiation logic.
// Assumes a single core clock, with the SD clock and CMD pins sampled as plain inputs.
// How it works
// - Fast SDR50, DDR50 and SDR104 timing is only allowed with low-voltage signalling.
// - Card starts at high-voltage signalling; only the switch command lowers it.
// - Low-voltage support is agreed in the operation-condition exchange by both sides.
// - Voltage switch command starts the switch sequence in the card.
// - A successful switch enters UHS-I operation with SDR12 timing by default.
// - In UHS-I, data transfers need the four-bit bus, except lock/unlock.
// - Switch function group 3 selects the output drive strength, which the card applies.
// - High-capacity cards take data addresses in 512-byte block units.
// - Card handles host capacity support and card capacity status bits.
// - After low-voltage entry, SPI and high-voltage return are refused until power-off.
// - Go-idle in low-voltage signalling keeps SDR12 timing.
// - Tuning is legal only in transfer state, low-voltage, unlocked; else illegal.
package uhs_neg_pkg;
   // Command frame layout (start, direction, index, argument, check, end)
   localparam int          FRAME_BITS  = 48;
   localparam int          POS_DIR     = 46;
   localparam int          POS_IDX_HI  = 45;
   localparam int          POS_IDX_LO  = 40;
   localparam int          POS_ARG_HI  = 39;
   localparam int          POS_ARG_LO  = 8;
   // Command indices
   localparam logic [5:0]  IDX_GO_IDLE = 6'h00;
   localparam logic [5:0]  IDX_SWITCH  = 6'h06;
   localparam logic [5:0]  IDX_VSWITCH = 6'h0b;
   localparam logic [5:0]  IDX_RD_ONE  = 6'h11;
   localparam logic [5:0]  IDX_RD_MANY = 6'h12;
   localparam logic [5:0]  IDX_TUNE    = 6'h13;
   localparam logic [5:0]  IDX_WR_ONE  = 6'h18;
   localparam logic [5:0]  IDX_WR_MANY = 6'h19;
   localparam logic [5:0]  IDX_OPCOND  = 6'h29;
   localparam logic [5:0]  IDX_LOCK    = 6'h2a;
   localparam logic [5:0]  IDX_APP     = 6'h37;
   localparam logic [5:0]  IDX_WIDTH   = 6'h06;
   // Argument fields
   localparam int          POS_S18R    = 24;
   localparam int          POS_HCS     = 30;
   localparam int          POS_SW_SET  = 31;
   localparam int          POS_G3_LO   = 8;
   localparam int          POS_G1_LO   = 0;
   localparam logic [3:0]  G_NOCHANGE  = 4'hf;
   localparam logic [3:0]  G3_MAX      = 4'h3;
   localparam logic [1:0]  WIDTH_4BIT  = 2'h2;
   localparam logic [1:0]  WIDTH_1BIT  = 2'h0;
   localparam int          BLK_SHIFT   = 9;
   // Timing modes: high-voltage codes first, then the UHS codes in group 1 order
   localparam logic [2:0]  TM_DS       = 3'h0;
   localparam logic [2:0]  TM_HS       = 3'h1;
   localparam logic [2:0]  TM_SDR12    = 3'h2;
   localparam logic [2:0]  TM_SDR25    = 3'h3;
   localparam logic [2:0]  TM_SDR50    = 3'h4;
   localparam logic [2:0]  TM_SDR104   = 3'h5;
   localparam logic [2:0]  TM_DDR50    = 3'h6;
   localparam logic [3:0]  G1_UHS_MAX  = 4'h4;
   localparam logic [3:0]  G1_HV_MAX   = 4'h1;
   // Reset values
   localparam logic [2:0]  RST_TIMING  = TM_DS;
   localparam logic [1:0]  RST_DRIVE   = 2'h0;
   // Frame capture states
   typedef enum logic [1:0] {
      FS_IDLE  = 2'b01,
      FS_SHIFT = 2'b10
   } frame_state_t;
endpackage : uhs_neg_pkg

/* verilog/uhs_signal_mode_negotiation.sv */
// Card-side UHS-I signalling level, timing mode and bus width negotiation.
// Captures host commands from the CMD pin on SD clock rising edges found by core_clk
// sampling; card status inputs come from logic on core_clk. Only power-off resets fully.
`timescale 1ns/1ps
module uhs_signal_mode_negotiation
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // SD pins
   input  wire logic        sd_clk,
   input  wire logic        sd_cmd_in,
   input  wire logic        sd_dat3_in,
   // Card status from core logic
   input  wire logic        card_s18_cap,
   input  wire logic        card_high_cap,
   input  wire logic        card_locked,
   input  wire logic        card_in_xfer,
   // Mode outputs
   output logic             sig_low_r,
   output logic             uhs_r,
   output logic [2:0]       timing_r,
   output logic             wide_bus_r,
   output logic [1:0]       drive_r,
   output logic             spi_mode_r,
   output logic             s18a_r,
   output logic             ccs_r,
   output logic             hcs_r,
   // Command outcome pulses and the held transfer block address
   output logic             illegal_r,
   output logic             vswitch_r,
   output logic             tune_ok_r,
   output logic             xfer_go_r,
   output logic [31:0]      blk_addr_r
);
   import uhs_neg_pkg::*;
   // Pin synchronisers; logic reads the second stage, and the third clock stage for rise detection
   logic [2:0] clk_s_r;
   logic [1:0] cmd_s_r, dat3_s_r;
   always_ff @(posedge core_clk) begin
      clk_s_r  <= {clk_s_r[1:0], sd_clk};
      cmd_s_r  <= {cmd_s_r[0], sd_cmd_in};
      dat3_s_r <= {dat3_s_r[0], sd_dat3_in};
   end

   logic sd_rise;
   assign sd_rise = clk_s_r[1] & ~clk_s_r[2];

   // Frame capture: a frame opens on a low start bit and closes after 48 bits
   frame_state_t       fs_r, fs_nxt;
   logic [47:0]        sh_r, sh_nxt;
   logic [5:0]         cnt_r, cnt_nxt;
   logic               done_r, done_nxt;
   always_comb begin
      fs_nxt   = fs_r;
      sh_nxt   = sh_r;
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      unique case (fs_r)
         FS_IDLE: begin
            if (sd_rise && !cmd_s_r[1]) begin
               fs_nxt  = FS_SHIFT;
               sh_nxt  = 48'h0;
               cnt_nxt = 6'h1;
            end
         end
         FS_SHIFT: begin
            if (sd_rise) begin
               sh_nxt  = {sh_r[46:0], cmd_s_r[1]};
               cnt_nxt = cnt_r + 6'h1;
               if (cnt_r == 6'(FRAME_BITS - 1)) begin
                  fs_nxt   = FS_IDLE;
                  done_nxt = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fs_r   <= FS_IDLE;
         sh_r   <= 48'h0;
         cnt_r  <= 6'h0;
         done_r <= 1'b0;
      end else begin
         fs_r   <= fs_nxt;
         sh_r   <= sh_nxt;
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   // Field views of the captured frame; direction and end bits must both be high
   logic        frame_ok;
   logic [5:0]  idx;
   logic [31:0] arg;
   assign frame_ok = done_r & sh_r[POS_DIR] & sh_r[0];
   assign idx      = sh_r[POS_IDX_HI:POS_IDX_LO];
   assign arg      = sh_r[POS_ARG_HI:POS_ARG_LO];

   // Command interpreter state
   logic       app_r, app_nxt;
   logic       neg_r, neg_nxt;
   logic       sig_low_nxt, uhs_nxt, wide_nxt, spi_nxt, s18a_nxt, ccs_nxt, hcs_nxt;
   logic       ill_nxt, vsw_nxt, tune_nxt, xgo_nxt;
   logic [2:0] timing_nxt;
   logic [1:0] drive_nxt;
   logic [31:0] addr_nxt;
   logic [3:0] g1, g3;
   assign g1 = arg[POS_G1_LO +: 4];
   assign g3 = arg[POS_G3_LO +: 4];

   always_comb begin
      app_nxt     = app_r;
      neg_nxt     = neg_r;
      sig_low_nxt = sig_low_r;
      uhs_nxt     = uhs_r;
      timing_nxt  = timing_r;
      wide_nxt    = wide_bus_r;
      drive_nxt   = drive_r;
      spi_nxt     = spi_mode_r;
      s18a_nxt    = s18a_r;
      ccs_nxt     = ccs_r;
      hcs_nxt     = hcs_r;
      addr_nxt    = blk_addr_r;
      ill_nxt     = 1'b0;
      vsw_nxt     = 1'b0;
      tune_nxt    = 1'b0;
      xgo_nxt     = 1'b0;
      if (frame_ok) begin
         app_nxt = 1'b0;
         if (app_r && idx == IDX_OPCOND) begin
            // Both sides must ask for low voltage before a switch is allowed
            s18a_nxt = arg[POS_S18R] & card_s18_cap;
            neg_nxt  = arg[POS_S18R] & card_s18_cap;
            hcs_nxt  = arg[POS_HCS];
            ccs_nxt  = card_high_cap;
         end else if (app_r && idx == IDX_WIDTH) begin
            // Bus width comes only by the application command
            if (arg[1:0] == WIDTH_4BIT)
               wide_nxt = 1'b1;
            else if (arg[1:0] == WIDTH_1BIT)
               wide_nxt = 1'b0;
         end else begin
            unique case (idx)
               IDX_APP: app_nxt = 1'b1;
               IDX_GO_IDLE: begin
                  wide_nxt = 1'b0;
                  neg_nxt  = 1'b0;
                  // Once low, SPI selection and timing fall-back are both refused
                  if (sig_low_r) begin
                     timing_nxt = TM_SDR12;
                  end else begin
                     timing_nxt = RST_TIMING;
                     spi_nxt    = ~dat3_s_r[1];
                  end
               end
               IDX_VSWITCH: begin
                  if (neg_r && !sig_low_r && !spi_mode_r) begin
                     sig_low_nxt = 1'b1;
                     vsw_nxt     = 1'b1;
                     uhs_nxt     = 1'b1;
                     timing_nxt  = TM_SDR12;
                  end else begin
                     ill_nxt = 1'b1;
                  end
               end
               IDX_SWITCH: begin
                  if (arg[POS_SW_SET]) begin
                     if (g3 != G_NOCHANGE && g3 <= G3_MAX)
                        drive_nxt = g3[1:0];
                     // Fast modes exist only in the UHS code range
                     if (g1 != G_NOCHANGE) begin
                        if (uhs_r && g1 <= G1_UHS_MAX)
                           timing_nxt = TM_SDR12 + g1[2:0];
                        else if (!uhs_r && g1 <= G1_HV_MAX)
                           timing_nxt = g1[2:0];
                     end
                  end
               end
               IDX_TUNE: begin
                  if (card_in_xfer && sig_low_r && !card_locked)
                     tune_nxt = 1'b1;
                  else
                     ill_nxt = 1'b1;
               end
               IDX_LOCK: xgo_nxt = 1'b1;
               IDX_RD_ONE, IDX_RD_MANY, IDX_WR_ONE, IDX_WR_MANY: begin
                  // A one-bit transfer in UHS is not assured, so it is refused
                  if (uhs_r && !wide_bus_r) begin
                     ill_nxt = 1'b1;
                  end else begin
                     xgo_nxt  = 1'b1;
                     addr_nxt = card_high_cap ? arg : (arg >> BLK_SHIFT);
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         app_r      <= 1'b0;
         neg_r      <= 1'b0;
         sig_low_r  <= 1'b0;
         uhs_r      <= 1'b0;
         timing_r   <= RST_TIMING;
         wide_bus_r <= 1'b0;
         drive_r    <= RST_DRIVE;
         spi_mode_r <= 1'b0;
         s18a_r     <= 1'b0;
         ccs_r      <= 1'b0;
         hcs_r      <= 1'b0;
         blk_addr_r <= 32'h0;
         illegal_r  <= 1'b0;
         vswitch_r  <= 1'b0;
         tune_ok_r  <= 1'b0;
         xfer_go_r  <= 1'b0;
      end else begin
         app_r      <= app_nxt;
         neg_r      <= neg_nxt;
         sig_low_r  <= sig_low_nxt;
         uhs_r      <= uhs_nxt;
         timing_r   <= timing_nxt;
         wide_bus_r <= wide_nxt;
         drive_r    <= drive_nxt;
         spi_mode_r <= spi_nxt;
         s18a_r     <= s18a_nxt;
         ccs_r      <= ccs_nxt;
         hcs_r      <= hcs_nxt;
         blk_addr_r <= addr_nxt;
         illegal_r  <= ill_nxt;
         vswitch_r  <= vsw_nxt;
         tune_ok_r  <= tune_nxt;
         xfer_go_r  <= xgo_nxt;
      end
   end

   // Checks on the mode outputs and command outcomes
   property p_fast_low;
      @(posedge core_clk) disable iff (!rst_n)
      (timing_r == TM_SDR50 || timing_r == TM_SDR104 || timing_r == TM_DDR50) |-> sig_low_r;
   endproperty
   a_fast_low: assert property (p_fast_low) else $error("fast mode without low level");
   property p_low_only_by_switch;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(sig_low_r) |-> vswitch_r && $past(frame_ok) && $past(idx) == IDX_VSWITCH;
   endproperty
   a_low_only_by_switch: assert property (p_low_only_by_switch) else $error("level changed outside switch");
   property p_s18a;
      @(posedge core_clk) disable iff (!rst_n)
      frame_ok && app_r && idx == IDX_OPCOND |=> s18a_r == ($past(arg[POS_S18R]) & $past(card_s18_cap));
   endproperty
   a_s18a: assert property (p_s18a) else $error("low-voltage reply wrong");
   property p_uhs_sdr12;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(uhs_r) |-> timing_r == TM_SDR12 && vswitch_r;
   endproperty
   a_uhs_sdr12: assert property (p_uhs_sdr12) else $error("UHS entry not at SDR12");
   property p_narrow_refused;
      @(posedge core_clk) disable iff (!rst_n)
      frame_ok && !app_r && idx == IDX_RD_ONE && uhs_r && !wide_bus_r |=> illegal_r && !xfer_go_r;
   endproperty
   a_narrow_refused: assert property (p_narrow_refused) else $error("one-bit transfer taken in UHS");
   property p_low_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      sig_low_r |=> sig_low_r && !spi_mode_r ##1 sig_low_r;
   endproperty
   a_low_sticky: assert property (p_low_sticky) else $error("left low-voltage signalling");
   property p_idle_sdr12;
      @(posedge core_clk) disable iff (!rst_n)
      frame_ok && !app_r && idx == IDX_GO_IDLE && sig_low_r |=> timing_r == TM_SDR12 && uhs_r;
   endproperty
   a_idle_sdr12: assert property (p_idle_sdr12) else $error("go-idle dropped SDR12");
   property p_tune;
      @(posedge core_clk) disable iff (!rst_n)
      frame_ok && !app_r && idx == IDX_TUNE |=> tune_ok_r == !illegal_r &&
         tune_ok_r == ($past(card_in_xfer) && $past(sig_low_r) && !$past(card_locked));
   endproperty
   a_tune: assert property (p_tune) else $error("tuning legality wrong");
   property p_switch_refused;
      @(posedge core_clk) disable iff (!rst_n)
      frame_ok && !app_r && idx == IDX_VSWITCH && !neg_r && !sig_low_r |=> illegal_r && !sig_low_r;
   endproperty
   a_switch_refused: assert property (p_switch_refused) else $error("switch taken without agreement");
   property p_block_addr;
      @(posedge core_clk) disable iff (!rst_n)
      frame_ok && !app_r && idx == IDX_WR_ONE && card_high_cap && !(uhs_r && !wide_bus_r)
         |=> xfer_go_r && blk_addr_r == $past(arg);
   endproperty
   a_block_addr: assert property (p_block_addr) else $error("block address wrong");
endmodule : uhs_signal_mode_negotiation

/* verification/sd_host_model.sv */
// Host model that sends command frames to the card on the SD clock and CMD pins.
// Assumes the card samples CMD on SD clock rises; the clock rests low between frames.
`timescale 1ns/1ps
module sd_host_model (
   // Pins toward the card
   output logic sd_clk,
   output logic sd_cmd
);
   // Clock stands still and CMD floats to its pull-up level outside frames
   initial begin
      sd_clk = 1'b0;
      sd_cmd = 1'b1;
   end
   // Frame: start, direction, index, argument, check field, end; CMD moves on the
   // falling edge so it is settled long before the card's delayed rise detection
   task automatic send(input logic [5:0] idx, input logic [31:0] arg);
      logic [47:0] frame;
      frame = {2'b01, idx, arg, 7'h00, 1'b1};
      for (int i = 47; i >= 0; i--) begin
         sd_cmd = frame[i];
         #80 sd_clk = 1'b1;
         #80 sd_clk = 1'b0;
      end
      sd_cmd = 1'b1;
   endtask : send
endmodule : sd_host_model

/* verification/tb_uhs_signal_mode_negotiation.sv */
// Self-checking bench for the card-side signalling negotiation block.
// Assumes the host model drives SD clock and CMD; card status inputs come from here.
`timescale 1ns/1ps
module tb_uhs_signal_mode_negotiation;
   import uhs_neg_pkg::*;
   logic        core_clk, rst_n, sd_clk, sd_cmd_in, sd_dat3_in;
   logic        card_s18_cap, card_high_cap, card_locked, card_in_xfer;
   logic        sig_low_r, uhs_r, wide_bus_r, spi_mode_r, s18a_r, ccs_r, hcs_r;
   logic        illegal_r, vswitch_r, tune_ok_r, xfer_go_r;
   logic [2:0]  timing_r;
   logic [1:0]  drive_r;
   logic [31:0] blk_addr_r;
   logic [7:0]  n_ill, n_vs, n_tune, n_go;
   int          err_count, check_count, cyc;

   uhs_signal_mode_negotiation uhs_signal_mode_negotiation_inst (
      .core_clk, .rst_n, .sd_clk, .sd_cmd_in, .sd_dat3_in, .card_s18_cap, .card_high_cap,
      .card_locked, .card_in_xfer, .sig_low_r, .uhs_r, .timing_r, .wide_bus_r, .drive_r,
      .spi_mode_r, .s18a_r, .ccs_r, .hcs_r, .illegal_r, .vswitch_r, .tune_ok_r, .xfer_go_r,
      .blk_addr_r);
   sd_host_model sd_host_model_inst (.sd_clk(sd_clk), .sd_cmd(sd_cmd_in));

   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   // Count outcome pulses, since they land while the frame is still on the wire
   always @(posedge core_clk) begin
      cyc++;
      if (illegal_r === 1'b1) n_ill++;
      if (vswitch_r === 1'b1) n_vs++;
      if (tune_ok_r === 1'b1) n_tune++;
      if (xfer_go_r === 1'b1) n_go++;
      if (cyc == 60000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Pulse counts packed as illegal, switch, tuning, transfer
   task automatic pul(input logic [31:0] e);
      chk("pulse counts", e, {n_ill, n_vs, n_tune, n_go});
   endtask : pul

   task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
      @(negedge core_clk);
      n_ill = 0;
      n_vs = 0;
      n_tune = 0;
      n_go = 0;
      sd_host_model_inst.send(idx, arg);
      repeat (10) @(negedge core_clk);
   endtask : cmd

   task automatic acmd(input logic [5:0] idx, input logic [31:0] arg);
      cmd(IDX_APP, 32'h0000_0000);
      cmd(idx, arg);
   endtask : acmd

   task automatic do_reset();
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask : do_reset

   task automatic t_reset();
      chk("sig_low_r", 0, sig_low_r);
      chk("timing_r", RST_TIMING, timing_r);
      chk("uhs_r", 0, uhs_r);
      chk("drive_r", RST_DRIVE, drive_r);
      chk("wide_bus_r", 0, wide_bus_r);
      chk("spi_mode_r", 0, spi_mode_r);
   endtask : t_reset

   // Host leaves out low-voltage request; switch and tuning must be refused
   task automatic t_no_neg();
      card_in_xfer = 1'b1;
      acmd(IDX_OPCOND, 32'h0000_0000);
      chk("s18a_r", 0, s18a_r);
      chk("hcs_r", 0, hcs_r);
      cmd(IDX_VSWITCH, 32'h0000_0000);
      pul(32'h0100_0000);
      chk("sig_low_r", 0, sig_low_r);
      cmd(IDX_TUNE, 32'h0000_0000);
      pul(32'h0100_0000);
   endtask : t_no_neg

   task automatic t_switch();
      acmd(IDX_OPCOND, (32'h1 << POS_S18R) | (32'h1 << POS_HCS));
      chk("s18a_r", 1, s18a_r);
      chk("ccs_r", 1, ccs_r);
      chk("hcs_r", 1, hcs_r);
      cmd(IDX_VSWITCH, 32'h0000_0000);
      pul(32'h0001_0000);
      chk("sig_low_r", 1, sig_low_r);
      chk("uhs_r", 1, uhs_r);
      chk("timing_r", TM_SDR12, timing_r);
   endtask : t_switch

   // Locked card on one-bit bus: only lock/unlock passes, then four-bit width
   task automatic t_width();
      logic [5:0] rw [4] = '{IDX_RD_ONE, IDX_RD_MANY, IDX_WR_ONE, IDX_WR_MANY};
      card_locked = 1'b1;
      cmd(IDX_RD_ONE, 32'h0000_1234);
      pul(32'h0100_0000);
      cmd(IDX_LOCK, 32'h0000_0000);
      pul(32'h0000_0001);
      card_locked = 1'b0;
      acmd(IDX_WIDTH, {30'h0, WIDTH_4BIT});
      chk("wide_bus_r", 1, wide_bus_r);
      for (int i = 0; i < 4; i++) begin
         cmd(rw[i], 32'h0012_3450 + i);
         pul(32'h0000_0001);
         chk("blk_addr_r", 32'h0012_3450 + i, blk_addr_r);
      end
   endtask : t_width

   // Every UHS timing code, and each drive strength; an out-of-range strength is ignored
   task automatic t_modes();
      logic [2:0] tm [5] = '{TM_SDR12, TM_SDR25, TM_SDR50, TM_SDR104, TM_DDR50};
      for (int i = 0; i < 5; i++) begin
         cmd(IDX_SWITCH, 32'h80ff_f0f0 | (i << 8) | i);
         chk("timing_r", tm[i], timing_r);
         chk("sig_low_r", 1, sig_low_r);
         chk("drive_r", (i < 4) ? i : 3, drive_r);
      end
   endtask : t_modes

   task automatic t_tune();
      cmd(IDX_TUNE, 32'h0000_0000);
      pul(32'h0000_0100);
      card_locked = 1'b1;
      cmd(IDX_TUNE, 32'h0000_0000);
      pul(32'h0100_0000);
      card_locked = 1'b0;
      card_in_xfer = 1'b0;
      cmd(IDX_TUNE, 32'h0000_0000);
      pul(32'h0100_0000);
   endtask : t_tune

   // Go-idle with chip select low must not leave low voltage or enter SPI
   task automatic t_idle();
      sd_dat3_in = 1'b0;
      cmd(IDX_GO_IDLE, 32'h0000_0000);
      chk("spi_mode_r", 0, spi_mode_r);
      chk("sig_low_r", 1, sig_low_r);
      chk("timing_r", TM_SDR12, timing_r);
      chk("wide_bus_r", 0, wide_bus_r);
      sd_dat3_in = 1'b1;
      cmd(IDX_VSWITCH, 32'h0000_0000);
      pul(32'h0100_0000);
   endtask : t_idle

   // Standard capacity card at high voltage: byte addresses, no fast modes, SPI allowed
   task automatic t_std();
      card_high_cap = 1'b0;
      card_s18_cap = 1'b0;
      do_reset();
      t_reset();
      acmd(IDX_OPCOND, (32'h1 << POS_S18R) | (32'h1 << POS_HCS));
      chk("s18a_r", 0, s18a_r);
      chk("ccs_r", 0, ccs_r);
      cmd(IDX_SWITCH, 32'h80ff_fff1);
      chk("timing_r", TM_HS, timing_r);
      cmd(IDX_SWITCH, 32'h80ff_fff4);
      chk("timing_r", TM_HS, timing_r);
      cmd(IDX_RD_ONE, 32'h0000_4200);
      chk("blk_addr_r", 32'h0000_0021, blk_addr_r);
      sd_dat3_in = 1'b0;
      cmd(IDX_GO_IDLE, 32'h0000_0000);
      chk("spi_mode_r", 1, spi_mode_r);
   endtask : t_std

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // Main sequence; each scenario up to t_idle relies on the state left by the previous one
   initial begin
      rst_n = 1'b0;
      sd_dat3_in = 1'b1;
      card_s18_cap = 1'b1;
      card_high_cap = 1'b1;
      card_locked = 1'b0;
      card_in_xfer = 1'b0;
      do_reset();
      t_reset();
      t_no_neg();
      t_switch();
      t_width();
      t_modes();
      t_tune();
      t_idle();
      t_std();
      end_of_test();
   end
endmodule : tb_uhs_signal_mode_negotiation
